//--- hdl/ilo_addr_gen.sv
/*
  Operand address generator: indexed or literal effective address.
  Assumes pointer and bank values are stable for the instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module ilo_addr_gen
  import ilo_pkg::*;
(
  input wire logic extEn, // Extension enabled
  input wire logic accessSel, // Bank select bit of opcode
  input wire logic [7:0] fileField, // File register field
  input wire logic [3:0] bankSel, // Bank select register
  input wire logic [ILO_ADDR_W-1:0] ptr2, // Indirect pointer 2
  output logic [ILO_ADDR_W-1:0] effAddr, // Effective data address
  output logic indexed // Indexed form in use
);
  always_comb begin
    // Only fields up to the limit
    indexed = extEn && !accessSel && (fileField <= ILO_OFS_MAX);
    if (indexed) begin
      effAddr = ptr2 + {{(ILO_ADDR_W-8){1'b0}}, fileField};
    end else if (accessSel) begin
      effAddr = {bankSel, fileField};
    end else if (fileField < ILO_ACCESS_SPLIT) begin
      effAddr = {4'h0, fileField};
    end else begin
      effAddr = {ILO_HIGH_BANK, fileField};
    end
  end
endmodule : ilo_addr_gen
`default_nettype wire

//--- hdl/ilo_decode.sv
/*
  Indexed literal offset decoder and executor for add, bit set and
  subtract-and-return. Assumes one instruction per four clock phases,
  data memory read data valid in the process phase.
*/
`timescale 1ns/1ps
`default_nettype none
module ilo_decode
  import ilo_pkg::*;
(
  input wire logic sys_clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic clkEn, // Clock enable
  input wire logic extSetEnable, // Extended set configuration bit
  input wire logic instrValid, // Instruction word present
  input wire logic [15:0] instr, // Instruction word
  input wire logic [3:0] bankSelReg, // Bank select register
  input wire logic [7:0] memRdData, // Data memory read data
  input wire logic [20:0] topOfStack, // Top-of-stack value
  output logic instrReady, // Ready for next instruction
  output logic [ILO_ADDR_W-1:0] memAddr, // Data memory address
  output logic memWrEn, // Data memory write strobe
  output logic [7:0] memWrData, // Data memory write data
  output logic [7:0] workAcc, // Working accumulator
  output logic [4:0] statusFlags, // N OV Z DC C
  output logic [ILO_ADDR_W-1:0] indPtr2, // Indirect pointer 2
  output logic pcLoad, // Program counter load pulse
  output logic [20:0] pcValue // Program counter load value
);
  typedef struct packed {
    ilo_qphase_t phase;
    ilo_op_t op;
    logic nopCycle;
    logic destFile;
    logic [2:0] bitNum;
    logic [7:0] offs;
    logic [ILO_ADDR_W-1:0] addr;
    logic [7:0] result;
    logic wr;
    logic [7:0] acc;
    logic [4:0] flags;
    logic [ILO_ADDR_W-1:0] ptr;
    logic pcLd;
    logic [20:0] pc;
    logic extLatched;
    logic rdy;
  } ilo_state_t;

  ilo_state_t cur_ff, nxt_ff;
  logic [ILO_ADDR_W-1:0] genAddr;
  logic genIndexed;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [7:0] sum7;

  // Indexed only with bank bit clear
  ilo_addr_gen uAddr (
    .extEn(cur_ff.extLatched),
    .accessSel(instr[8]),
    .fileField(instr[7:0]),
    .bankSel(bankSelReg),
    .ptr2(cur_ff.ptr),
    .effAddr(genAddr),
    .indexed(genIndexed)
  );

  function automatic ilo_op_t decodeOp(input logic [15:0] w, input logic idx);
    if (w[15:6] == ILO_SUBR_OPC)
      return ILO_OP_SUBR;
    else if (idx && w[15:10] == ILO_ADD_OPC && !w[8])
      return ILO_OP_ADD;
    else if (idx && w[15:12] == ILO_BSF_OPC && !w[8])
      return ILO_OP_BSF;
    return ILO_OP_NONE;
  endfunction : decodeOp

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wr = 1'b0;
    nxt_ff.pcLd = 1'b0;
    sum = {1'b0, cur_ff.acc} + {1'b0, memRdData};
    lowSum = {1'b0, cur_ff.acc[3:0]} + {1'b0, memRdData[3:0]};
    sum7 = {1'b0, cur_ff.acc[6:0]} + {1'b0, memRdData[6:0]};
    nxt_ff.extLatched = extSetEnable;
    case (cur_ff.phase)
      ILO_QDEC: begin
        if (cur_ff.nopCycle) begin
          nxt_ff.nopCycle = 1'b0;
          nxt_ff.phase = ILO_QRD;
          nxt_ff.op = ILO_OP_NONE;
        end else if (instrValid) begin
          nxt_ff.op = cur_ff.extLatched ? decodeOp(instr, genIndexed) : ILO_OP_NONE;
          nxt_ff.destFile = instr[9];
          nxt_ff.bitNum = instr[11:9];
          nxt_ff.phase = ILO_QRD;
        end
      end
      ILO_QRD: begin
        nxt_ff.offs = instr[7:0];
        // Zero pointer maps to access RAM
        nxt_ff.addr = genAddr;
        nxt_ff.phase = ILO_QPROC;
      end
      ILO_QPROC: begin
        nxt_ff.phase = ILO_QWR;
        case (cur_ff.op)
          ILO_OP_ADD: begin
            nxt_ff.result = sum[7:0];
            nxt_ff.flags[ILO_FLG_C] = sum[8];
            nxt_ff.flags[ILO_FLG_DC] = lowSum[4];
            nxt_ff.flags[ILO_FLG_Z] = (sum[7:0] == 8'h00);
            nxt_ff.flags[ILO_FLG_N] = sum[7];
            nxt_ff.flags[ILO_FLG_OV] = sum7[7] ^ sum[8];
          end
          ILO_OP_BSF: begin
            nxt_ff.result = memRdData | (8'h01 << cur_ff.bitNum);
          end
          ILO_OP_SUBR: begin
            nxt_ff.ptr = cur_ff.ptr - {{(ILO_ADDR_W-6){1'b0}}, cur_ff.offs[5:0]};
          end
          default: begin
            nxt_ff.result = cur_ff.result;
          end
        endcase
      end
      ILO_QWR: begin
        nxt_ff.phase = ILO_QDEC;
        case (cur_ff.op)
          ILO_OP_ADD: begin
            if (cur_ff.destFile)
              nxt_ff.wr = 1'b1;
            else
              nxt_ff.acc = cur_ff.result;
          end
          ILO_OP_BSF: nxt_ff.wr = 1'b1;
          ILO_OP_SUBR: begin
            nxt_ff.pcLd = 1'b1;
            nxt_ff.pc = topOfStack;
            nxt_ff.nopCycle = 1'b1;
          end
          default: nxt_ff.wr = 1'b0;
        endcase
      end
      default: nxt_ff.phase = ILO_QDEC;
    endcase
    // Registered so the ready output comes from a flop
    nxt_ff.rdy = (nxt_ff.phase == ILO_QDEC) && !nxt_ff.nopCycle;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_ff <= '{phase: ILO_QDEC, op: ILO_OP_NONE, nopCycle: 1'b0, destFile: 1'b0,
                  bitNum: 3'h0, offs: 8'h00, addr: ILO_PTR_RST, result: 8'h00, wr: 1'b0,
                  acc: ILO_ACC_RST, flags: 5'h00, ptr: ILO_PTR_RST, pcLd: 1'b0,
                  pc: 21'h000000, extLatched: 1'b0, rdy: 1'b1};
    end else if (clkEn) begin
      cur_ff <= nxt_ff;
    end
  end

  assign instrReady = cur_ff.rdy;
  assign memAddr = cur_ff.addr;
  assign memWrEn = cur_ff.wr;
  assign memWrData = cur_ff.result;
  assign workAcc = cur_ff.acc;
  assign statusFlags = cur_ff.flags;
  assign indPtr2 = cur_ff.ptr;
  assign pcLoad = cur_ff.pcLd;
  assign pcValue = cur_ff.pc;

  // Write strobe only after an add to file or a bit set
  chk_write_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(memWrEn) |-> $past(cur_ff.op) inside {ILO_OP_ADD, ILO_OP_BSF})
    else $error("Write without add or bit set");
  chk_bsf_noflags: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && cur_ff.op == ILO_OP_BSF) |=> $stable(statusFlags))
    else $error("Bit set changed flags");
  chk_ret_nop: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && pcLoad) |-> (cur_ff.nopCycle && !instrReady))
    else $error("Return without idle cycle");
  chk_ext_off: assert property (@(posedge sys_clk) disable iff (rst)
    (!cur_ff.extLatched && cur_ff.phase == ILO_QDEC && clkEn && instrValid) |=> cur_ff.op == ILO_OP_NONE)
    else $error("Extended op while disabled");
  chk_zero_ptr: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && cur_ff.phase == ILO_QRD && genIndexed && cur_ff.ptr == 12'h000)
      |=> memAddr == {4'h0, $past(instr[7:0])})
    else $error("Zero pointer not access RAM");
  chk_idx_limit: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && cur_ff.phase == ILO_QRD && !instr[8] && instr[7:0] > ILO_OFS_MAX)
      |=> memAddr == {ILO_HIGH_BANK, $past(instr[7:0])})
    else $error("High field not literal access bank");
  chk_idx_add: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && cur_ff.phase == ILO_QRD && genIndexed)
      |=> memAddr == $past(cur_ff.ptr) + {4'h0, $past(instr[7:0])})
    else $error("Bad indexed address");
  chk_phase_seq: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && cur_ff.phase == ILO_QRD) |=> cur_ff.phase == ILO_QPROC)
    else $error("Phase order broken");
  chk_add_dest: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && cur_ff.phase == ILO_QWR && cur_ff.op == ILO_OP_ADD) |=> memWrEn == $past(cur_ff.destFile))
    else $error("Add destination select broken");
endmodule : ilo_decode
`default_nettype wire

//--- hdl/ilo_pkg.sv
/*
  Constants for the indexed literal offset operand decoder.
  Assumes a 16-bit instruction word and 12-bit data addresses.
*/
package ilo_pkg;
  localparam int unsigned ILO_ADDR_W = 12;
  localparam logic [7:0] ILO_OFS_MAX = 8'h5F;
  localparam logic [5:0] ILO_ADD_OPC = 6'h09;
  localparam logic [3:0] ILO_BSF_OPC = 4'h8;
  localparam logic [9:0] ILO_SUBR_OPC = 10'h3A7;
  localparam logic [3:0] ILO_BANK_RST = 4'h0;
  localparam logic [ILO_ADDR_W-1:0] ILO_PTR_RST = 12'h000;
  localparam logic [7:0] ILO_ACC_RST = 8'h00;
  localparam logic [7:0] ILO_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ILO_HIGH_BANK = 4'hF;
  localparam int unsigned ILO_FLG_N = 4;
  localparam int unsigned ILO_FLG_OV = 3;
  localparam int unsigned ILO_FLG_Z = 2;
  localparam int unsigned ILO_FLG_DC = 1;
  localparam int unsigned ILO_FLG_C = 0;
  typedef enum logic [1:0] {ILO_QDEC, ILO_QRD, ILO_QPROC, ILO_QWR} ilo_qphase_t;
  typedef enum logic [1:0] {ILO_OP_NONE, ILO_OP_ADD, ILO_OP_BSF, ILO_OP_SUBR} ilo_op_t;
endpackage : ilo_pkg

//--- tb/ilo_decode_test.sv
/*
  Self-checking bench for ilo_decode: literal and indexed operand
  addressing, indexed add and bit set, subtract-and-return.
  Assumes one instruction per four enabled cycles and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ilo_decode_test;
  import ilo_pkg::*;
  logic sys_clk, rst, clkEn, extSetEnable, instrValid, instrReady, memWrEn, pcLoad;
  logic [15:0] instr;
  logic [3:0] bankSelReg;
  logic [7:0] memRdData, memWrData, workAcc, wd;
  logic [20:0] topOfStack, pcValue;
  logic [ILO_ADDR_W-1:0] memAddr, indPtr2;
  logic [4:0] statusFlags;
  int failures, samples_checked, nWr, nPc;

  ilo_decode ilo_decode_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .extSetEnable(extSetEnable),
    .instrValid(instrValid), .instr(instr), .bankSelReg(bankSelReg), .memRdData(memRdData),
    .topOfStack(topOfStack), .instrReady(instrReady), .memAddr(memAddr), .memWrEn(memWrEn),
    .memWrData(memWrData), .workAcc(workAcc), .statusFlags(statusFlags), .indPtr2(indPtr2),
    .pcLoad(pcLoad), .pcValue(pcValue));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic cmp_val(input string what, input logic [20:0] exp, input logic [20:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  // Waits for ready, then presents one instruction for a single enabled edge
  task automatic launch(input logic [15:0] w, input logic [7:0] rd);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    cmp_val("instrReady", 21'h1, {20'h0, instrReady});
    instr = w;
    memRdData = rd;
    instrValid = 1'b1;
    @(negedge sys_clk);
    instrValid = 1'b0;
    nWr = 0;
    nPc = 0;
  endtask : launch

  // Strobes are counted over a wide slot so a one-cycle pulse is never missed
  task automatic collect(input int k);
    repeat (k) begin
      @(negedge sys_clk);
      if (memWrEn === 1'b1) begin
        nWr++;
        wd = memWrData;
      end
      if (pcLoad === 1'b1) nPc++;
    end
  endtask : collect

  task automatic issue(input logic [15:0] w, input logic [7:0] rd);
    launch(w, rd);
    collect(5);
  endtask : issue

  // Flag is registered, so let one edge pass before the next instruction
  task automatic set_ext(input logic e);
    extSetEnable = e;
    @(negedge sys_clk);
  endtask : set_ext

  task automatic t_off;
    set_ext(1'b0);
    issue(16'h242C, 8'h20);
    cmp_val("litAddr", 21'h02C, 21'(memAddr));
    cmp_val("accOff", 21'h0, 21'(workAcc));
    cmp_val("wrOff", 21'h0, 21'(nWr));
    issue(16'h252C, 8'h20);
    cmp_val("bankAddr", 21'h32C, 21'(memAddr));
    $display("test off done");
  endtask : t_off

  task automatic add_step(input logic [15:0] w, input logic [7:0] rd, input logic [7:0] accExp,
                          input logic [4:0] flExp, input logic [7:0] wdExp, input logic wrExp);
    issue(w, rd);
    cmp_val("idxAddr", 21'h02C, 21'(memAddr));
    cmp_val("acc", 21'(accExp), 21'(workAcc));
    cmp_val("flags", 21'(flExp), 21'(statusFlags));
    cmp_val("wrCount", 21'(wrExp), 21'(nWr));
    if (wrExp) cmp_val("wrData", 21'(wdExp), 21'(wd));
  endtask : add_step

  task automatic t_add;
    set_ext(1'b1);
    add_step(16'h242C, 8'h20, 8'h20, 5'h00, 8'h00, 1'h0);
    add_step(16'h262C, 8'hE0, 8'h20, 5'h05, 8'h00, 1'h1);
    add_step(16'h242C, 8'h6F, 8'h8F, 5'h18, 8'h00, 1'h0);
    add_step(16'h242C, 8'h71, 8'h00, 5'h07, 8'h00, 1'h0);
    $display("test add done");
  endtask : t_add

  task automatic t_high;
    issue(16'h2460, 8'h01);
    cmp_val("highAddr", 21'hF60, 21'(memAddr));
    cmp_val("highAcc", 21'h0, 21'(workAcc));
    issue(16'h252C, 8'h01);
    cmp_val("bankAddr", 21'h32C, 21'(memAddr));
    cmp_val("bankWr", 21'h0, 21'(nWr));
    $display("test high done");
  endtask : t_high

  task automatic t_ret;
    issue(16'hE9E3, 8'h00);
    cmp_val("pcCount", 21'h1, 21'(nPc));
    cmp_val("pcValue", 21'h0A5A5, pcValue);
    cmp_val("ptr", 21'hFDD, 21'(indPtr2));
    cmp_val("retIdle", 21'h0, {20'h0, instrReady});
    $display("test ret done");
  endtask : t_ret

  task automatic t_bsf;
    for (int b = 0; b < 8; b++) begin
      issue(16'h800A | (16'(b) << 9), 8'h55);
      cmp_val("bsfAddr", 21'hFE7, 21'(memAddr));
      cmp_val("bsfWr", 21'h1, 21'(nWr));
      cmp_val("bsfData", {13'h0, 8'h55 | (8'h01 << b)}, 21'(wd));
      cmp_val("bsfFlags", 21'h07, 21'(statusFlags));
    end
    $display("test bsf done");
  endtask : t_bsf

  // Stall right after decode; the pointer sum must wrap at 12 bits
  task automatic t_freeze;
    launch(16'h262C, 8'h01);
    clkEn = 1'b0;
    collect(6);
    cmp_val("frzWr", 21'h0, 21'(nWr));
    cmp_val("frzAddr", 21'hFE7, 21'(memAddr));
    cmp_val("frzFlagsHeld", 21'h07, 21'(statusFlags));
    clkEn = 1'b1;
    collect(5);
    cmp_val("wrapAddr", 21'h009, 21'(memAddr));
    cmp_val("frzWrCnt", 21'h1, 21'(nWr));
    cmp_val("frzData", 21'h01, 21'(wd));
    cmp_val("frzFlags", 21'h00, 21'(statusFlags));
    cmp_val("frzAcc", 21'h00, 21'(workAcc));
    $display("test freeze done");
  endtask : t_freeze

  // Pointer is nonzero here, so literal and indexed addresses differ
  task automatic t_toggle;
    set_ext(1'b0);
    issue(16'h242C, 8'h20);
    cmp_val("offLitAddr", 21'h02C, 21'(memAddr));
    cmp_val("offAcc", 21'h0, 21'(workAcc));
    issue(16'hE9E3, 8'h00);
    cmp_val("offPc", 21'h0, 21'(nPc));
    cmp_val("offPtr", 21'hFDD, 21'(indPtr2));
    $display("test toggle done");
  endtask : t_toggle

  task automatic t_reset;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    cmp_val("rstAddr", 21'h0, 21'(memAddr));
    cmp_val("rstPtr", 21'h0, 21'(indPtr2));
    cmp_val("rstAcc", 21'h0, 21'(workAcc));
    cmp_val("rstFlags", 21'h0, 21'(statusFlags));
    cmp_val("rstReady", 21'h1, {20'h0, instrReady});
    // Enable flop is cleared by reset, so reload it before the first word
    set_ext(1'b1);
    issue(16'h242C, 8'h20);
    cmp_val("rstIdxAddr", 21'h02C, 21'(memAddr));
    cmp_val("rstIdxAcc", 21'h20, 21'(workAcc));
    $display("test reset done");
  endtask : t_reset

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial begin
    #(40 * 3000);
    failures++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    extSetEnable = 1'b0;
    instrValid = 1'b0;
    instr = 16'h0000;
    bankSelReg = 4'h3;
    memRdData = 8'h00;
    topOfStack = 21'h0A5A5;
    failures = 0;
    samples_checked = 0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    t_off();
    t_add();
    t_high();
    t_ret();
    t_bsf();
    t_freeze();
    t_toggle();
    t_reset();
    print_verdict();
  end
endmodule : ilo_decode_test
`default_nettype wire
